// [verilog/slcs_device_end.sv]
// Converter end: link registers, status and two-lane character generator
//
// Functional notes
// - Software disables link before changing settings
// - Config bit 7 turns scrambler on
// - Bits 6:2 hold frames per multiframe minus one
// - Software keeps frames per multiframe 17 to 32
// - Software writes one to config bit 1
// - Link enable runs normal synchronization and data
// - Disabled link sends alternating 01010101 pattern
// - Codes 1-3 select PRBS7, PRBS15, PRBS23
// - Code 9 static low, code 10 high
// - Software avoids reserved test pattern codes
// - Sixteen-bit ramp step, resets to one
// - Software never programs ramp step zero
// - Polarity bits 3 and 2 invert lanes
// - Software writes zeros to reserved bits
// - Status register layout; two flags writable
// - Link up only once data flows
// - Sync request low four frames starts sync
// - Write one or clock loss clears flags
// - SYSREF sets align; phase shift sets moved
module slcs_device_end
	import slcs_pkg::*;
(
	// Clock and reset
	input  wire logic        sys_clk,
	input  wire logic        reset_n,
	// Link to the receiver side
	slcs_link_if.device      link,
	// Converter side
	input  wire logic [15:0] sample,
	input  wire logic        clockPresentPin,
	input  wire logic        pllLockPin,
	input  wire logic        calDonePin,
	output logic             linkEnabled
);
	typedef enum logic [2:0] {ST_IDLE, ST_WAIT, ST_CGS, ST_ILA, ST_DATA} slcs_dev_state_t;

	slcs_dev_state_t state;
	logic [7:0]  linkCfg;
	logic [7:0]  testPat;
	logic [7:0]  rampLo;
	logic [7:0]  rampHi;
	logic [7:0]  lanePol;
	logic [4:0]  pinMeta;
	logic [4:0]  pinSync;
	logic        sysrefPrev;
	logic [2:0]  syncLowCount;
	logic [4:0]  frameCount;
	logic [1:0]  ilaCount;
	logic [15:0] rampValue;
	logic [22:0] prbsState;
	logic [14:0] scramble0;
	logic [14:0] scramble1;
	logic        alignFlag;
	logic        phaseMoved;
	logic [7:0]  next_byte0;
	logic [7:0]  next_byte1;
	logic [1:0]  next_k;
	logic [22:0] next_prbs;
	logic [14:0] next_scramble0;
	logic [14:0] next_scramble1;
	logic [4:0]  framesLessOne;
	logic [3:0]  patCode;
	logic        syncIn;
	logic        sysrefRise;
	logic        clockOk;
	logic        linkUp;
	logic        statWrite;
	logic [15:0] dataWord;
	logic [22:0] scrOut0;
	logic [22:0] scrOut1;
	logic [8:0]  ilaOut;

	function automatic logic [22:0] prbsStep(input logic [22:0] s, input logic [1:0] sel);
		logic        fb;
		logic [22:0] r;
		r = s;
		fb = 1'b0;
		for (int i = 0; i < 8; i++) begin
			case (sel)
				2'h1: fb = r[6] ^ r[5];
				2'h2: fb = r[14] ^ r[13];
				default: fb = r[22] ^ r[17];
			endcase
			r = {r[21:0], fb};
		end
		return r;
	endfunction

	// Self-synchronous 1 + x^14 + x^15, returns {state, byte}
	function automatic logic [22:0] scrambleByte(input logic [14:0] s, input logic [7:0] d);
		logic [14:0] r;
		logic [7:0]  q;
		r = s;
		q = 8'h00;
		for (int i = 7; i >= 0; i--) begin
			q[i] = d[i] ^ r[14] ^ r[13];
			r = {r[13:0], q[i]};
		end
		return {r, q};
	endfunction

	// Alignment sequence character, returns {k, byte}
	function automatic logic [8:0] ilaChar(input logic [4:0] f, input logic [4:0] last,
		input logic [1:0] mf);
		if (f == 5'h00)
			return {1'b1, CHAR_K28_0};
		else if (f == last)
			return {1'b1, CHAR_K28_3};
		else if (mf == 2'h1 && f == 5'h01)
			return {1'b1, CHAR_K28_4};
		else
			return {1'b0, 3'h0, f};
	endfunction

	assign framesLessOne = linkCfg[CFG_FRAMES_HI:CFG_FRAMES_LO];
	assign patCode       = testPat[3:0];
	assign syncIn        = pinSync[4];
	assign clockOk       = pinSync[0];
	assign sysrefRise    = pinSync[3] & ~sysrefPrev;
	assign linkUp        = (state == ST_DATA);
	assign statWrite     = link.regWr && (link.regAddr == ADDR_LINK_STAT);
	assign linkEnabled   = linkCfg[CFG_ENABLE_BIT];

	// Pin synchronisers: sync request, SYSREF, clock, PLL, calibration
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			pinMeta    <= 5'h11;
			pinSync    <= 5'h11;
			sysrefPrev <= 1'b0;
		end else begin
			pinMeta    <= {link.syncReq_n, link.sysref, pllLockPin, calDonePin, clockPresentPin};
			pinSync    <= pinMeta;
			sysrefPrev <= pinSync[3];
		end
	end

	// Register writes; fields stored as written
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			linkCfg <= RST_LINK_CFG;
			testPat <= RST_TEST_PAT;
			rampLo  <= RST_RAMP_LO;
			rampHi  <= RST_RAMP_HI;
			lanePol <= RST_LANE_POL;
		end else if (link.regWr) begin
			if (link.regAddr == ADDR_LINK_CFG)
				linkCfg <= link.regWdata;
			else if (link.regAddr == ADDR_TEST_PAT)
				testPat <= link.regWdata;
			else if (link.regAddr == ADDR_RAMP_LO)
				rampLo <= link.regWdata;
			else if (link.regAddr == ADDR_RAMP_HI)
				rampHi <= link.regWdata;
			else if (link.regAddr == ADDR_LANE_POL)
				lanePol <= link.regWdata;
		end
	end

	// Register reads, answer in the following cycle
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			link.regRdata <= 8'h00;
		end else if (link.regRd) begin
			if (link.regAddr == ADDR_LINK_CFG)
				link.regRdata <= linkCfg;
			else if (link.regAddr == ADDR_TEST_PAT)
				link.regRdata <= testPat;
			else if (link.regAddr == ADDR_RAMP_LO)
				link.regRdata <= rampLo;
			else if (link.regAddr == ADDR_RAMP_HI)
				link.regRdata <= rampHi;
			else if (link.regAddr == ADDR_LANE_POL)
				link.regRdata <= lanePol;
			else if (link.regAddr == ADDR_LINK_STAT)
				link.regRdata <= {1'b0, linkUp, state != ST_CGS, phaseMoved, alignFlag,
					pinSync[2], pinSync[1], clockOk};
			else
				link.regRdata <= 8'h00;
		end else begin
			link.regRdata <= 8'h00;
		end
	end

	// SYSREF flags; hardware set wins over software clear
	always_ff @(posedge sys_clk) begin
		if (!reset_n || !clockOk) begin
			alignFlag  <= 1'b0;
			phaseMoved <= 1'b0;
		end else begin
			alignFlag  <= sysrefRise
				| (alignFlag & ~(statWrite & link.regWdata[STAT_ALIGN_BIT]));
			phaseMoved <= (sysrefRise && frameCount != 5'h00)
				| (phaseMoved & ~(statWrite & link.regWdata[STAT_MOVED_BIT]));
		end
	end

	// Local frame and multiframe counters
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			frameCount <= 5'h00;
			ilaCount   <= 2'h0;
		end else if (sysrefRise) begin
			frameCount <= 5'h00;
			ilaCount   <= 2'h0;
		end else if (frameCount >= framesLessOne) begin
			frameCount <= 5'h00;
			ilaCount   <= (state == ST_ILA || patCode == TP_ILA) ? ilaCount + 2'h1 : 2'h0;
		end else begin
			frameCount <= frameCount + 5'h01;
		end
	end

	// Length of the receiver's sync request
	always_ff @(posedge sys_clk) begin
		if (!reset_n || syncIn)
			syncLowCount <= 3'h0;
		else if (syncLowCount < SYNC_MIN_FRAMES)
			syncLowCount <= syncLowCount + 3'h1;
	end

	// Link synchronization sequence
	always_ff @(posedge sys_clk) begin
		if (!reset_n || !linkCfg[CFG_ENABLE_BIT]) begin
			state <= ST_IDLE;
		end else begin
			case (state)
				ST_IDLE: state <= ST_WAIT;
				ST_CGS:
					if (syncIn && frameCount >= framesLessOne)
						state <= ST_ILA;
				ST_ILA:
					if (syncLowCount == SYNC_MIN_FRAMES)
						state <= ST_CGS;
					else if (frameCount >= framesLessOne && ilaCount == ILA_LAST_MF)
						state <= ST_DATA;
				default:
					if (syncLowCount == SYNC_MIN_FRAMES)
						state <= ST_CGS;
			endcase
		end
	end

	// Ramp source advances once per sample in data phase
	always_ff @(posedge sys_clk) begin
		if (!reset_n || patCode != TP_RAMP)
			rampValue <= 16'h0000;
		else if (state == ST_DATA)
			rampValue <= rampValue + {rampHi, rampLo};
	end

	assign dataWord = (patCode == TP_RAMP) ? rampValue : sample;
	assign scrOut0  = scrambleByte(scramble0, dataWord[15:8]);
	assign scrOut1  = scrambleByte(scramble1, dataWord[7:0]);
	assign ilaOut   = ilaChar(frameCount, framesLessOne, ilaCount);

	// Lane character selection
	always_comb begin
		next_byte0     = CHAR_ALT;
		next_byte1     = CHAR_ALT;
		next_k         = 2'b00;
		next_prbs      = prbsState;
		next_scramble0 = scramble0;
		next_scramble1 = scramble1;
		if (linkCfg[CFG_ENABLE_BIT]) begin
			case (patCode)
				TP_PRBS7, TP_PRBS15, TP_PRBS23: begin
					next_prbs  = prbsStep(prbsState, patCode[1:0]);
					next_byte0 = next_prbs[7:0];
					next_byte1 = next_prbs[7:0];
				end
				TP_ILA: begin
					next_byte0 = ilaOut[7:0];
					next_byte1 = ilaOut[7:0];
					next_k     = {2{ilaOut[8]}};
				end
				TP_K285: begin
					next_byte0 = CHAR_K28_5;
					next_byte1 = CHAR_K28_5;
					next_k     = 2'b11;
				end
				TP_D215: begin
					next_byte0 = CHAR_D21_5;
					next_byte1 = CHAR_D21_5;
				end
				TP_LOW: begin
					next_byte0 = CHAR_LOW;
					next_byte1 = CHAR_LOW;
				end
				TP_HIGH: begin
					next_byte0 = CHAR_HIGH;
					next_byte1 = CHAR_HIGH;
				end
				default: begin
					case (state)
						ST_ILA: begin
							next_byte0 = ilaOut[7:0];
							next_byte1 = ilaOut[7:0];
							next_k     = {2{ilaOut[8]}};
						end
						ST_DATA: begin
							if (linkCfg[CFG_SCRAMBLE_BIT]) begin
								next_byte0     = scrOut0[7:0];
								next_byte1     = scrOut1[7:0];
								next_scramble0 = scrOut0[22:8];
								next_scramble1 = scrOut1[22:8];
							end else begin
								next_byte0 = dataWord[15:8];
								next_byte1 = dataWord[7:0];
							end
						end
						default: begin
							next_byte0 = CHAR_K28_5;
							next_byte1 = CHAR_K28_5;
							next_k     = 2'b11;
						end
					endcase
				end
			endcase
		end
	end

	// Lane outputs with polarity inversion
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			link.laneData0 <= CHAR_ALT;
			link.laneData1 <= CHAR_ALT;
			link.laneCharK <= 2'b00;
			prbsState      <= '1;
			scramble0      <= '1;
			scramble1      <= '1;
		end else begin
			link.laneData0 <= next_byte0 ^ {8{lanePol[POL_LANE0_BIT]}};
			link.laneData1 <= next_byte1 ^ {8{lanePol[POL_LANE1_BIT]}};
			link.laneCharK <= next_k;
			prbsState      <= next_prbs;
			scramble0      <= next_scramble0;
			scramble1      <= next_scramble1;
		end
	end
endmodule

// [verilog/slcs_pkg.sv]
// Shared constants for the serial link configuration and status block
package slcs_pkg;
	// Device register offsets
	localparam logic [7:0] ADDR_LINK_CFG  = 8'h60;
	localparam logic [7:0] ADDR_TEST_PAT  = 8'h61;
	localparam logic [7:0] ADDR_RAMP_LO   = 8'h62;
	localparam logic [7:0] ADDR_RAMP_HI   = 8'h63;
	localparam logic [7:0] ADDR_LANE_POL  = 8'h64;
	localparam logic [7:0] ADDR_LINK_STAT = 8'h6C;
	// Device reset values
	localparam logic [7:0] RST_LINK_CFG   = 8'h7F;
	localparam logic [7:0] RST_TEST_PAT   = 8'h00;
	localparam logic [7:0] RST_RAMP_LO    = 8'h01;
	localparam logic [7:0] RST_RAMP_HI    = 8'h00;
	localparam logic [7:0] RST_LANE_POL   = 8'h00;
	// Field positions
	localparam int CFG_SCRAMBLE_BIT = 7;
	localparam int CFG_FRAMES_HI    = 6;
	localparam int CFG_FRAMES_LO    = 2;
	localparam int CFG_RESV_BIT     = 1;
	localparam int CFG_ENABLE_BIT   = 0;
	localparam int POL_LANE1_BIT    = 3;
	localparam int POL_LANE0_BIT    = 2;
	localparam int STAT_MOVED_BIT   = 4;
	localparam int STAT_ALIGN_BIT   = 3;
	localparam logic [7:0] TEST_PAT_MASK = 8'h0F;
	localparam logic [7:0] LANE_POL_MASK = 8'h0C;
	localparam logic [7:0] CFG_RESV_ONE  = 8'h02;
	localparam logic [4:0] FRAMES_MIN_CODE = 5'h10;
	// Test pattern codes
	localparam logic [3:0] TP_NORMAL = 4'h0;
	localparam logic [3:0] TP_PRBS7  = 4'h1;
	localparam logic [3:0] TP_PRBS15 = 4'h2;
	localparam logic [3:0] TP_PRBS23 = 4'h3;
	localparam logic [3:0] TP_RESV4  = 4'h4;
	localparam logic [3:0] TP_ILA    = 4'h5;
	localparam logic [3:0] TP_RAMP   = 4'h6;
	localparam logic [3:0] TP_K285   = 4'h7;
	localparam logic [3:0] TP_D215   = 4'h8;
	localparam logic [3:0] TP_LOW    = 4'h9;
	localparam logic [3:0] TP_HIGH   = 4'hA;
	// Line characters
	localparam logic [7:0] CHAR_ALT   = 8'h55;
	localparam logic [7:0] CHAR_K28_5 = 8'hBC;
	localparam logic [7:0] CHAR_D21_5 = 8'hB5;
	localparam logic [7:0] CHAR_K28_0 = 8'h1C;
	localparam logic [7:0] CHAR_K28_3 = 8'h7C;
	localparam logic [7:0] CHAR_K28_4 = 8'h9C;
	localparam logic [7:0] CHAR_LOW   = 8'h00;
	localparam logic [7:0] CHAR_HIGH  = 8'hFF;
	// Timing in frame clocks (one frame per sys_clk)
	localparam logic [2:0] SYNC_MIN_FRAMES = 3'h4;
	localparam logic [1:0] ILA_LAST_MF     = 2'h3;
	// Host command registers
	localparam logic [7:0] HC_CTRL   = 8'h00;
	localparam logic [7:0] HC_ADDR   = 8'h01;
	localparam logic [7:0] HC_WDATA  = 8'h02;
	localparam logic [7:0] HC_RREQ   = 8'h03;
	localparam logic [7:0] HC_RDATA  = 8'h04;
	localparam logic [7:0] HC_STAT   = 8'h05;
	localparam int HC_SYNC_BIT    = 0;
	localparam int HC_SYSREF_BIT  = 1;
	localparam int HC_REFUSED_BIT = 1;
endpackage

// [verilog/slcs_link_if.sv]
// Signals between the converter's link end and the receiver side
interface slcs_link_if;
	logic [7:0] regAddr;
	logic [7:0] regWdata;
	logic       regWr;
	logic       regRd;
	logic [7:0] regRdata;
	logic       syncReq_n;
	logic       sysref;
	logic [7:0] laneData0;
	logic [7:0] laneData1;
	logic [1:0] laneCharK;

	modport device (
		input  regAddr, regWdata, regWr, regRd, syncReq_n, sysref,
		output regRdata, laneData0, laneData1, laneCharK
	);
	modport host (
		output regAddr, regWdata, regWr, regRd, syncReq_n, sysref,
		input  regRdata, laneData0, laneData1, laneCharK
	);
endinterface

// [verilog/slcs_host_end.sv]
// Receiver-side controller: safe register programming and sync request
module slcs_host_end
	import slcs_pkg::*;
(
	// Clock and reset
	input  wire logic       sys_clk,
	input  wire logic       reset_n,
	// Command port
	input  wire logic [7:0] cmdAddr,
	input  wire logic [7:0] cmdWdata,
	input  wire logic       cmdWr,
	input  wire logic       cmdRd,
	output logic      [7:0] cmdRdata,
	// Link to the converter
	slcs_link_if.host       link
);
	typedef enum logic [2:0] {H_IDLE, H_DISABLE, H_WRITE, H_READ, H_CAPTURE} slcs_host_state_t;

	slcs_host_state_t state;
	logic [7:0] tgtAddr;
	logic [7:0] pendData;
	logic [7:0] rdResult;
	logic [7:0] shadowCfg;
	logic [7:0] rampLoShadow;
	logic [7:0] rampHiShadow;
	logic       refused;
	logic       syncRequest;
	logic       syncActive;
	logic [2:0] holdCount;
	logic       sysrefPulse;
	logic       launchWr;
	logic       launchRd;
	logic       illegal;
	logic       isCfgReg;
	logic [7:0] cleanData;

	// Values the converter must never receive
	function automatic logic badValue(input logic [7:0] a, input logic [7:0] v,
		input logic [7:0] lo, input logic [7:0] hi);
		if (a == ADDR_LINK_CFG)
			return v[CFG_FRAMES_HI:CFG_FRAMES_LO] < FRAMES_MIN_CODE;
		else if (a == ADDR_TEST_PAT)
			return v[3:0] == TP_RESV4 || v[3:0] > TP_HIGH;
		else if (a == ADDR_RAMP_LO)
			return {hi, v} == 16'h0000;
		else if (a == ADDR_RAMP_HI)
			return {v, lo} == 16'h0000;
		else
			return 1'b0;
	endfunction

	assign launchWr = cmdWr && cmdAddr == HC_WDATA;
	assign launchRd = cmdWr && cmdAddr == HC_RREQ;
	assign illegal  = badValue(tgtAddr, cmdWdata, rampLoShadow, rampHiShadow);
	assign isCfgReg = tgtAddr >= ADDR_LINK_CFG && tgtAddr <= ADDR_LANE_POL;

	always_comb begin
		if (tgtAddr == ADDR_LINK_CFG)
			cleanData = cmdWdata | CFG_RESV_ONE;
		else if (tgtAddr == ADDR_TEST_PAT)
			cleanData = cmdWdata & TEST_PAT_MASK;
		else if (tgtAddr == ADDR_LANE_POL)
			cleanData = cmdWdata & LANE_POL_MASK;
		else
			cleanData = cmdWdata;
	end

	assign link.regWr    = (state == H_DISABLE) || (state == H_WRITE);
	assign link.regRd    = (state == H_READ);
	assign link.regAddr  = (state == H_DISABLE) ? ADDR_LINK_CFG : tgtAddr;
	assign link.regWdata = (state == H_DISABLE) ? (shadowCfg & ~8'h01) : pendData;
	assign link.syncReq_n = ~syncActive;
	assign link.sysref    = sysrefPulse;

	// Command registers
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			tgtAddr     <= 8'h00;
			syncRequest <= 1'b0;
			sysrefPulse <= 1'b0;
		end else begin
			sysrefPulse <= cmdWr && cmdAddr == HC_CTRL && cmdWdata[HC_SYSREF_BIT];
			if (cmdWr && cmdAddr == HC_CTRL)
				syncRequest <= cmdWdata[HC_SYNC_BIT];
			else if (cmdWr && cmdAddr == HC_ADDR)
				tgtAddr <= cmdWdata;
		end
	end

	// Refusal flag; a new refusal wins over its clear
	always_ff @(posedge sys_clk) begin
		if (!reset_n)
			refused <= 1'b0;
		else if ((launchWr || launchRd) && (state != H_IDLE || (launchWr && illegal)))
			refused <= 1'b1;
		else if (cmdWr && cmdAddr == HC_STAT && cmdWdata[HC_REFUSED_BIT])
			refused <= 1'b0;
	end

	// Converter access sequencer
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			state        <= H_IDLE;
			pendData     <= 8'h00;
			shadowCfg    <= RST_LINK_CFG;
			rampLoShadow <= RST_RAMP_LO;
			rampHiShadow <= RST_RAMP_HI;
		end else begin
			case (state)
				H_IDLE:
					if (launchWr && !illegal) begin
						pendData <= cleanData;
						if (isCfgReg && shadowCfg[CFG_ENABLE_BIT])
							state <= H_DISABLE;
						else
							state <= H_WRITE;
					end else if (launchRd) begin
						state <= H_READ;
					end
				H_DISABLE: begin
					shadowCfg <= shadowCfg & ~8'h01;
					state     <= H_WRITE;
				end
				H_WRITE: begin
					if (tgtAddr == ADDR_LINK_CFG)
						shadowCfg <= pendData;
					else if (tgtAddr == ADDR_RAMP_LO)
						rampLoShadow <= pendData;
					else if (tgtAddr == ADDR_RAMP_HI)
						rampHiShadow <= pendData;
					state <= H_IDLE;
				end
				H_READ: state <= H_CAPTURE;
				default: state <= H_IDLE;
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!reset_n)
			rdResult <= 8'h00;
		else if (state == H_CAPTURE)
			rdResult <= link.regRdata;
	end

	// Sync request held low at least four frame clocks
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			syncActive <= 1'b0;
			holdCount  <= 3'h0;
		end else if (syncRequest) begin
			syncActive <= 1'b1;
			if (holdCount < SYNC_MIN_FRAMES)
				holdCount <= holdCount + 3'h1;
		end else if (syncActive && holdCount < SYNC_MIN_FRAMES) begin
			holdCount <= holdCount + 3'h1;
		end else begin
			syncActive <= 1'b0;
			holdCount  <= 3'h0;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			cmdRdata <= 8'h00;
		end else if (cmdRd) begin
			if (cmdAddr == HC_CTRL)
				cmdRdata <= {7'h00, syncRequest};
			else if (cmdAddr == HC_ADDR)
				cmdRdata <= tgtAddr;
			else if (cmdAddr == HC_WDATA)
				cmdRdata <= pendData;
			else if (cmdAddr == HC_RDATA)
				cmdRdata <= rdResult;
			else if (cmdAddr == HC_STAT)
				cmdRdata <= {5'h00, syncActive, refused, state != H_IDLE};
			else
				cmdRdata <= 8'h00;
		end else begin
			cmdRdata <= 8'h00;
		end
	end
endmodule

// [testbench/slcs_link_assertions.sv]
// Concurrent checks on the link between host end and device end
module slcs_link_assertions
	import slcs_pkg::*;
(
	// Clock and reset
	input wire logic       sys_clk,
	input wire logic       reset_n,
	// Register port
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWdata,
	input wire logic       regWr,
	input wire logic       regRd,
	input wire logic [7:0] regRdata,
	// Sync and lanes
	input wire logic       syncReq_n,
	input wire logic       sysref,
	input wire logic [7:0] laneData0,
	input wire logic [7:0] laneData1,
	input wire logic [1:0] laneCharK
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] shadow [5];
	logic [7:0] rdExp;
	logic [7:0] tc;
	logic [7:0] m0;
	logic [7:0] m1;
	logic [2:0] quiet;
	logic       inDev;
	logic       fixed;

	// Mirror of the device registers as written
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			shadow <= '{RST_LINK_CFG, RST_TEST_PAT, RST_RAMP_LO, RST_RAMP_HI, RST_LANE_POL};
		end else if (regWr && inDev) begin
			shadow[regAddr[2:0]] <= regWdata;
		end
	end
	// Cycles since the last write, saturating
	always_ff @(posedge sys_clk) begin
		if (!reset_n || regWr) begin
			quiet <= 3'h0;
		end else if (quiet != 3'h7) begin
			quiet <= quiet + 3'h1;
		end
	end
	always_comb begin
		inDev = regAddr >= ADDR_LINK_CFG && regAddr <= ADDR_LANE_POL;
		rdExp = inDev ? shadow[regAddr[2:0]] : 8'h00;
		m0 = {8{shadow[4][POL_LANE0_BIT]}};
		m1 = {8{shadow[4][POL_LANE1_BIT]}};
		fixed = 1'b1;
		case (shadow[1][3:0])
			TP_LOW: tc = CHAR_LOW;
			TP_HIGH: tc = CHAR_HIGH;
			TP_K285: tc = CHAR_K28_5;
			TP_D215: tc = CHAR_D21_5;
			default: begin
				tc = CHAR_ALT;
				fixed = 1'b0;
			end
		endcase
	end

	default clocking @(posedge sys_clk); endclocking
	default disable iff (!reset_n);
	sequence syncHeld;
		!syncReq_n [*3];
	endsequence

	chk_rd_idle_zero: assert property (!regRd |=> regRdata == 8'h00)
		else $error("read data not zero outside a read");
	chk_rd_reg_value: assert property (
		regRd && regAddr != ADDR_LINK_STAT |=> regRdata == $past(rdExp))
		else $error("read data differs from written value");
	chk_strobe_single: assert property (!(regWr && regRd))
		else $error("write and read strobes together");
	chk_cfg_resv_one: assert property (
		regWr && regAddr == ADDR_LINK_CFG |-> regWdata[CFG_RESV_BIT])
		else $error("config reserved bit written as zero");
	chk_write_when_off: assert property (
		regWr && inDev && regAddr != ADDR_LINK_CFG |-> !shadow[0][CFG_ENABLE_BIT])
		else $error("setting changed while link enabled");
	chk_idle_alt_char: assert property (
		quiet > 3'h2 && !shadow[0][CFG_ENABLE_BIT]
		|-> laneData0 == (CHAR_ALT ^ m0) && laneData1 == (CHAR_ALT ^ m1))
		else $error("disabled lanes not alternating");
	chk_test_char: assert property (
		quiet > 3'h2 && shadow[0][CFG_ENABLE_BIT] && fixed
		|-> laneData0 == (tc ^ m0) && laneData1 == (tc ^ m1)
		&& (shadow[1][3:0] != TP_K285 || laneCharK == 2'b11))
		else $error("fixed test character wrong");
	chk_sysref_pulse: assert property (sysref |=> !sysref)
		else $error("sysref longer than one cycle");
	chk_sync_hold: assert property ($fell(syncReq_n) |=> syncHeld)
		else $error("sync request low under four frames");
endmodule

// [testbench/testbench.sv]
// Self-checking bench joining host end and device end
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import slcs_pkg::*;
	logic        sys_clk = 1'b0;
	logic        reset_n = 1'b0;
	logic [7:0]  cmdAddr = 8'h00;
	logic [7:0]  cmdWdata = 8'h00;
	logic        cmdWr = 1'b0;
	logic        cmdRd = 1'b0;
	logic [7:0]  cmdRdata;
	logic [15:0] sample = 16'hA55A;
	logic        clkPres = 1'b1;
	logic        linkEnabled;
	logic [7:0]  rd;
	logic [15:0] r1;
	int          err_count = 0;
	int          checked = 0;
	int          cycles = 0;

	slcs_link_if lk ();
	slcs_device_end slcs_device_end_inst (.sys_clk(sys_clk), .reset_n(reset_n), .link(lk),
		.sample(sample), .clockPresentPin(clkPres), .pllLockPin(1'b1), .calDonePin(1'b1),
		.linkEnabled(linkEnabled));
	slcs_host_end slcs_host_end_inst (.sys_clk(sys_clk), .reset_n(reset_n), .cmdAddr(cmdAddr),
		.cmdWdata(cmdWdata), .cmdWr(cmdWr), .cmdRd(cmdRd), .cmdRdata(cmdRdata), .link(lk));
	slcs_link_assertions slcs_link_assertions_inst (.sys_clk(sys_clk), .reset_n(reset_n),
		.regAddr(lk.regAddr), .regWdata(lk.regWdata), .regWr(lk.regWr), .regRd(lk.regRd),
		.regRdata(lk.regRdata), .syncReq_n(lk.syncReq_n), .sysref(lk.sysref),
		.laneData0(lk.laneData0), .laneData1(lk.laneData1), .laneCharK(lk.laneCharK));

	always #10 sys_clk = ~sys_clk;

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			err_count++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	task automatic hostWr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		cmdAddr <= a;
		cmdWdata <= d;
		cmdWr <= 1'b1;
		@(posedge sys_clk);
		cmdWr <= 1'b0;
	endtask
	task automatic hostRd(input logic [7:0] a, output logic [7:0] d);
		@(posedge sys_clk);
		cmdAddr <= a;
		cmdRd <= 1'b1;
		@(posedge sys_clk);
		cmdRd <= 1'b0;
		#1 d = cmdRdata;
	endtask
	task automatic waitIdle();
		int n;
		n = 0;
		rd = 8'h01;
		while (rd[0] !== 1'b0 && n < 20) begin
			hostRd(HC_STAT, rd);
			n++;
		end
		check(rd[0], 1'b0);
	endtask
	task automatic devWr(input logic [7:0] a, input logic [7:0] d);
		hostWr(HC_ADDR, a);
		hostWr(HC_WDATA, d);
		waitIdle();
	endtask
	task automatic devRd(input logic [7:0] a);
		hostWr(HC_ADDR, a);
		hostWr(HC_RREQ, 8'h00);
		waitIdle();
		hostRd(HC_RDATA, rd);
	endtask
	task automatic lanesAre(input logic [15:0] exp);
		repeat (4) @(posedge sys_clk);
		#1 check({lk.laneData0, lk.laneData1}, exp);
	endtask
	task automatic syncUp();
		devWr(ADDR_LINK_CFG, 8'h7F);
		hostWr(HC_CTRL, 8'h01);
		repeat (10) @(posedge sys_clk);
		hostWr(HC_CTRL, 8'h00);
		repeat (300) @(posedge sys_clk);
	endtask

	task automatic testResetValues();
		logic [7:0] tab [5] = '{RST_LINK_CFG, RST_TEST_PAT, RST_RAMP_LO, RST_RAMP_HI, RST_LANE_POL};
		for (int i = 0; i < 5; i++) begin
			devRd(ADDR_LINK_CFG + 8'(i));
			check(rd, tab[i]);
		end
		devRd(8'h70);
		check(rd, 8'h00);
	endtask
	task automatic testCodes();
		logic [3:0] codes [4] = '{TP_LOW, TP_HIGH, TP_K285, TP_D215};
		logic [7:0] chars [4] = '{CHAR_LOW, CHAR_HIGH, CHAR_K28_5, CHAR_D21_5};
		for (int i = 0; i < 4; i++) begin
			devWr(ADDR_TEST_PAT, {4'h0, codes[i]});
			devRd(ADDR_LINK_CFG);
			check(rd, 8'h7E);
			check(linkEnabled, 1'b0);
			lanesAre({CHAR_ALT, CHAR_ALT});
			devWr(ADDR_LINK_CFG, 8'h7F);
			lanesAre({chars[i], chars[i]});
		end
	endtask
	task automatic testPolarity();
		devWr(ADDR_LANE_POL, 8'hFF);
		devRd(ADDR_LANE_POL);
		check(rd, 8'h0C);
		lanesAre({~CHAR_ALT, ~CHAR_ALT});
		devWr(ADDR_LANE_POL, 8'h04);
		lanesAre({~CHAR_ALT, CHAR_ALT});
		devWr(ADDR_LANE_POL, 8'h00);
	endtask
	task automatic testRefusals();
		logic [7:0] addrs [4] = '{ADDR_TEST_PAT, ADDR_TEST_PAT, ADDR_LINK_CFG, ADDR_RAMP_LO};
		logic [7:0] vals [4] = '{8'h04, 8'h0B, 8'h3C, 8'h00};
		for (int i = 0; i < 4; i++) begin
			devWr(addrs[i], vals[i]);
			hostRd(HC_STAT, rd);
			check(rd[HC_REFUSED_BIT], 1'b1);
			hostWr(HC_STAT, 8'h02);
		end
		devRd(ADDR_TEST_PAT);
		check(rd, {4'h0, TP_D215});
		devWr(ADDR_LINK_CFG, 8'hC0);
		devRd(ADDR_LINK_CFG);
		check(rd, 8'hC2);
	endtask
	task automatic testLink();
		devWr(ADDR_TEST_PAT, {4'h0, TP_NORMAL});
		syncUp();
		devRd(ADDR_LINK_STAT);
		check(rd & 8'hE7, 8'h67);
		#1 check({lk.laneData0, lk.laneData1}, sample);
		devWr(ADDR_RAMP_LO, 8'h03);
		devWr(ADDR_RAMP_HI, 8'h01);
		devWr(ADDR_TEST_PAT, {4'h0, TP_RAMP});
		syncUp();
		#1 r1 = {lk.laneData0, lk.laneData1};
		@(posedge sys_clk);
		#1 check({lk.laneData0, lk.laneData1} - r1, 16'h0103);
	endtask
	task automatic testSysref();
		hostWr(HC_CTRL, 8'h02);
		devRd(ADDR_LINK_STAT);
		check(rd[STAT_ALIGN_BIT], 1'b1);
		devWr(ADDR_LINK_STAT, 8'h18);
		devRd(ADDR_LINK_STAT);
		check(rd[4:3], 2'b00);
		hostWr(HC_CTRL, 8'h02);
		clkPres <= 1'b0;
		devRd(ADDR_LINK_STAT);
		check(rd[4:3], 2'b00);
		check(rd[0], 1'b0);
		@(posedge sys_clk);
		clkPres <= 1'b1;
	endtask

	task automatic summarize();
		$display("mismatches %0d comparisons %0d", err_count, checked);
		if (err_count == 0 && checked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	always @(posedge sys_clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			err_count++;
			summarize();
		end
	end

	initial begin
		repeat (4) @(posedge sys_clk);
		reset_n <= 1'b1;
		testResetValues();
		testCodes();
		testPolarity();
		testRefusals();
		testLink();
		testSysref();
		summarize();
	end
endmodule
